// [hw/spwc_pkg.sv]
// Package for the serial port width control register bank
package spwc_pkg;
    // Byte address of the port lane control register
    localparam logic [11:0] SPWC_PORT_LANE_CONTROL_ADDR = 12'h015c;
    // LSB-numbered bit positions (documented bit n sits at 31-n)
    localparam int SPWC_CAP_MSB       = 31;
    localparam int SPWC_CAP_LSB       = 30;
    localparam int SPWC_INIT_MSB      = 29;
    localparam int SPWC_INIT_LSB      = 27;
    localparam int SPWC_OVR_MSB       = 26;
    localparam int SPWC_OVR_LSB       = 24;
    localparam int SPWC_DIS_BIT       = 23;
    localparam int SPWC_OUT_EN_BIT    = 22;
    localparam int SPWC_IN_EN_BIT     = 21;
    localparam int SPWC_EXT_OVR_MSB   = 15;
    localparam int SPWC_EXT_OVR_LSB   = 14;
    // Reset values
    localparam logic [2:0] SPWC_OVR_RST    = 3'h0;
    localparam logic [2:0] SPWC_INIT_RST   = 3'h0;
    localparam logic       SPWC_DIS_RST    = 1'h0;
    localparam logic       SPWC_OUT_EN_RST = 1'h0;
    localparam logic       SPWC_IN_EN_RST  = 1'h0;
    // Override codes
    localparam logic [2:0] SPWC_OVR_NONE   = 3'h0;
    localparam logic [2:0] SPWC_OVR_X1     = 3'h2;
    localparam logic [2:0] SPWC_OVR_X1_R   = 3'h3;
    localparam logic [2:0] SPWC_OVR_X2     = 3'h5;
    localparam logic [2:0] SPWC_OVR_X4     = 3'h6;
    localparam logic [2:0] SPWC_OVR_X2X4   = 3'h7;
    // Bus answer states
    typedef enum logic [1:0] {
        SPWC_IDLE = 2'b01,
        SPWC_ACK  = 2'b10
    } spwc_bus_t;
    typedef struct packed {
        spwc_bus_t  bus;
        logic [31:0] rdata;
        logic [2:0] ovr;
        logic       dis;
        logic       out_en;
        logic       in_en;
        logic [1:0] ext_ovr;
        logic [2:0] init_w;
        logic       reinit;
    } spwc_state_t;
endpackage

// [hw/spwc_core.sv]
// Port lane control register with width-mode decode and traffic gating
// Functional notes
// - Bits 0:1 read-only capability: bit0 four-lane, bit1 two-lane; single always.
// - Bits 2:4 read-only negotiated width code, reset zero.
// - Bits 5:7 writable width override, reset 000 meaning no override.
// - Override codes: 010/011 single, 101 two, 110 four, 111 both.
// - Override bits 6 and 7 are interpreted according to bit 5.
// - Never enable a width the capability bits mark unsupported.
// - Writing a changed override value restarts link initialization.
// - Bit 8 disable blocks all packets and control symbols both ways.
// - Output enable clear: only maintenance packets sent; symbols still sent.
// - Input enable clear: non-maintenance packets answered with not-accepted.
// - Control symbols always handled while input disabled; set accepts all.
// - Output and input enable reset values are configurable, default clear.
// - Extended override bits 16:17 apply only when override bit 5 is one.
module spwc_core #(
    parameter logic [1:0] CAP_WIDTH    = 2'h3,            // Bit1 two-lane, bit0 four-lane
    parameter logic [1:0] CAP_EXT      = 2'h0,            // Bit1 eight, bit0 sixteen
    parameter logic       OUT_EN_RESET = spwc_pkg::SPWC_OUT_EN_RST, // Reset of output enable
    parameter logic       IN_EN_RESET  = spwc_pkg::SPWC_IN_EN_RST   // Reset of input enable
) (
    input  wire logic        ref_clk,       // Register clock
    input  wire logic        rstn,          // Asynchronous reset, active low
    input  wire logic        wb_cyc_i,      // Wishbone cycle
    input  wire logic        wb_stb_i,      // Wishbone strobe
    input  wire logic        wb_we_i,       // Wishbone write
    input  wire logic [11:0] wb_adr_i,      // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,      // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,      // Wishbone write data
    output logic      [31:0] wb_dat_o,      // Wishbone read data
    output logic             wb_ack_o,      // Wishbone acknowledge
    input  wire logic        init_done,     // Training finished, width valid
    input  wire logic [2:0]  init_width,    // Width code reached by training
    output logic             reinit_req,    // One-cycle restart of training
    output logic             en_x1,         // Single lane offered
    output logic             en_x1_r,       // Single lane, redundant lane
    output logic             en_x2,         // Two-lane offered
    output logic             en_x4,         // Four-lane offered
    output logic             en_x8,         // Eight-lane offered
    output logic             en_x16,        // Sixteen-lane offered
    output logic             port_off,      // Drivers and receivers disabled
    input  wire logic        tx_req,        // Packet waiting to send
    input  wire logic        tx_maint,      // Waiting packet is maintenance
    output logic             tx_allow,      // Packet may be sent
    input  wire logic        tx_sym_req,    // Control symbol waiting to send
    output logic             tx_sym_allow,  // Control symbol may be sent
    input  wire logic        rx_pkt,        // Packet received, one-cycle pulse
    input  wire logic        rx_maint,      // Received packet is maintenance
    output logic             rx_accept,     // Packet accepted
    output logic             rx_reject,     // Answer with packet-not-accepted
    input  wire logic        rx_sym,        // Control symbol received
    output logic             rx_sym_take    // Control symbol handled
);
    import spwc_pkg::*;

    spwc_state_t cur;
    spwc_state_t next_cur;
    logic        hit;
    logic        wr;
    logic [2:0]  new_ovr;
    logic [31:0] rd_word;

    assign hit = wb_cyc_i && wb_stb_i && (cur.bus == SPWC_IDLE);
    assign wr  = hit && wb_we_i && (wb_adr_i == SPWC_PORT_LANE_CONTROL_ADDR);

    // Documented bits 5:7 live in byte lane 3 (bits 31:24)
    assign new_ovr = wb_sel_i[3] ? wb_dat_i[SPWC_OVR_MSB:SPWC_OVR_LSB] : cur.ovr;

    always_comb begin
        rd_word = 32'h0000_0000;
        // Documented bit 0 (four-lane) is word bit 31, bit 1 (two-lane) is word bit 30
        rd_word[SPWC_CAP_MSB]                = CAP_WIDTH[0];
        rd_word[SPWC_CAP_LSB]                = CAP_WIDTH[1];
        rd_word[SPWC_INIT_MSB:SPWC_INIT_LSB] = cur.init_w;
        rd_word[SPWC_OVR_MSB:SPWC_OVR_LSB]   = cur.ovr;
        rd_word[SPWC_DIS_BIT]                = cur.dis;
        rd_word[SPWC_OUT_EN_BIT]             = cur.out_en;
        rd_word[SPWC_IN_EN_BIT]              = cur.in_en;
        rd_word[SPWC_EXT_OVR_MSB:SPWC_EXT_OVR_LSB] = cur.ext_ovr;
    end

    always_comb begin
        next_cur        = cur;
        next_cur.reinit = 1'b0;
        case (cur.bus)
            SPWC_IDLE: begin
                if (hit) begin
                    next_cur.bus   = SPWC_ACK;
                    next_cur.rdata = (wb_adr_i == SPWC_PORT_LANE_CONTROL_ADDR) ?
                                     rd_word : 32'h0000_0000;
                end
            end
            SPWC_ACK: begin
                next_cur.bus = SPWC_IDLE;
            end
            default: begin
                next_cur.bus = SPWC_IDLE;
            end
        endcase
        if (wr) begin
            // Capability and width bits are not taken from the write
            next_cur.ovr = new_ovr;
            if (new_ovr != cur.ovr) begin
                next_cur.reinit = 1'b1;
            end
            if (wb_sel_i[2]) begin
                next_cur.dis    = wb_dat_i[SPWC_DIS_BIT];
                next_cur.out_en = wb_dat_i[SPWC_OUT_EN_BIT];
                next_cur.in_en  = wb_dat_i[SPWC_IN_EN_BIT];
            end
            // Extended override holds no capability by default, kept as plain storage
            if (wb_sel_i[1]) begin
                next_cur.ext_ovr = wb_dat_i[SPWC_EXT_OVR_MSB:SPWC_EXT_OVR_LSB];
            end
        end
        // Width is only meaningful once training reports done; a restart clears it
        if (cur.reinit) begin
            next_cur.init_w = SPWC_INIT_RST;
        end else if (init_done) begin
            next_cur.init_w = init_width;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cur         <= '0;
            cur.bus     <= SPWC_IDLE;
            cur.ovr     <= SPWC_OVR_RST;
            cur.dis     <= SPWC_DIS_RST;
            cur.out_en  <= OUT_EN_RESET;
            cur.in_en   <= IN_EN_RESET;
            cur.init_w  <= SPWC_INIT_RST;
        end else begin
            cur <= next_cur;
        end
    end

    assign wb_ack_o   = (cur.bus == SPWC_ACK);
    assign wb_dat_o   = cur.rdata;
    assign reinit_req = cur.reinit;
    assign port_off   = cur.dis;

    // Width decode; reserved codes fall back to single lane only
    always_comb begin
        en_x1   = 1'b1;
        en_x1_r = 1'b0;
        en_x2   = 1'b0;
        en_x4   = 1'b0;
        en_x8   = 1'b0;
        en_x16  = 1'b0;
        case (cur.ovr)
            SPWC_OVR_NONE: begin
                en_x2  = CAP_WIDTH[1];
                en_x4  = CAP_WIDTH[0];
                en_x8  = CAP_EXT[1];
                en_x16 = CAP_EXT[0];
            end
            SPWC_OVR_X1: begin
                en_x1 = 1'b1;
            end
            SPWC_OVR_X1_R: begin
                en_x1   = 1'b0;
                en_x1_r = 1'b1;
            end
            SPWC_OVR_X2, SPWC_OVR_X4, SPWC_OVR_X2X4: begin
                // With bit 5 set, bit 6 (ovr[1]) enables four-lane, bit 7 (ovr[0]) two-lane
                en_x2  = cur.ovr[0] & CAP_WIDTH[1];
                en_x4  = cur.ovr[1] & CAP_WIDTH[0];
                en_x8  = cur.ext_ovr[1] & CAP_EXT[1];
                en_x16 = cur.ext_ovr[0] & CAP_EXT[0];
            end
            default: begin
                en_x1 = 1'b1;
            end
        endcase
    end

    // Maintenance traffic always passes enable gating; disable blocks everything
    assign tx_allow     = tx_req && !cur.dis && (cur.out_en || tx_maint);
    assign tx_sym_allow = tx_sym_req && !cur.dis;
    assign rx_accept    = rx_pkt && !cur.dis && (cur.in_en || rx_maint);
    assign rx_reject    = rx_pkt && !cur.dis && !cur.in_en && !rx_maint;
    assign rx_sym_take  = rx_sym && !cur.dis;

    bus_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
    reinit_chg_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr && new_ovr != cur.ovr) |=> reinit_req)
        else $error("override change did not restart training");
    reinit_same_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        reinit_req |-> $past(wr) && cur.ovr != $past(cur.ovr))
        else $error("restart without override change");
    cap_mask_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!en_x2 || CAP_WIDTH[1]) && (!en_x4 || CAP_WIDTH[0]))
        else $error("unsupported width enabled");
    force_x1_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cur.ovr == SPWC_OVR_X1 |-> en_x1 && !en_x2 && !en_x4 && !en_x8)
        else $error("forced single lane not honoured");
    ext_ignore_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !cur.ovr[2] |-> !(en_x8 && cur.ovr != SPWC_OVR_NONE))
        else $error("extended override used while bit 5 clear");
    tx_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        tx_allow |-> !port_off && (cur.out_en || tx_maint))
        else $error("non-maintenance packet sent while output disabled");
    rx_reject_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rx_pkt && !cur.dis && !cur.in_en && !rx_maint) |-> rx_reject && !rx_accept)
        else $error("packet not refused while input disabled");
    rx_sym_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rx_sym && !port_off) |-> rx_sym_take)
        else $error("control symbol dropped");
    ro_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr && !init_done && !reinit_req) |=> cur.init_w == $past(cur.init_w))
        else $error("initialized width changed by write");

    // Bus answer: one acknowledge per request, data registered from the decode
    ack_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!(wb_cyc_i && wb_stb_i) && !wb_ack_o) |=> !wb_ack_o)
        else $error("acknowledge without request");
    ack_single_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    rdata_map_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (hit && !wb_we_i && wb_adr_i == SPWC_PORT_LANE_CONTROL_ADDR) |=> wb_dat_o == $past(rd_word))
        else $error("read data differs from register");
    rdata_unmapped_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (hit && wb_adr_i != SPWC_PORT_LANE_CONTROL_ADDR) |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !hit |=> $stable(wb_dat_o))
        else $error("read data changed without access");
    cap_field_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wb_ack_o && $past(wb_adr_i == SPWC_PORT_LANE_CONTROL_ADDR))
        |-> wb_dat_o[SPWC_CAP_MSB:SPWC_CAP_LSB] == {CAP_WIDTH[0], CAP_WIDTH[1]})
        else $error("capability field wrong");

    // Initialized width follows training only; software cannot touch it
    init_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        reinit_req |=> cur.init_w == SPWC_INIT_RST)
        else $error("width not cleared on restart");
    init_take_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (init_done && !reinit_req) |=> cur.init_w == $past(init_width))
        else $error("trained width not captured");
    init_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!init_done && !reinit_req) |=> $stable(cur.init_w))
        else $error("initialized width moved without training");

    // Writable fields change only under their byte select
    ovr_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr && wb_sel_i[3]) |=> cur.ovr == $past(wb_dat_i[SPWC_OVR_MSB:SPWC_OVR_LSB]))
        else $error("override write lost");
    ovr_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(wr && wb_sel_i[3]) |=> $stable(cur.ovr))
        else $error("override changed without write");
    ctrl_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr && wb_sel_i[2]) |=> port_off == $past(wb_dat_i[SPWC_DIS_BIT]))
        else $error("disable write lost");
    en_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr && wb_sel_i[2]) |=> cur.out_en == $past(wb_dat_i[SPWC_OUT_EN_BIT])
        && cur.in_en == $past(wb_dat_i[SPWC_IN_EN_BIT]))
        else $error("enable write lost");
    ctrl_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(wr && wb_sel_i[2]) |=> $stable(port_off) && $stable(cur.out_en) && $stable(cur.in_en))
        else $error("control bits changed without write");
    ext_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr && wb_sel_i[1]) |=> cur.ext_ovr == $past(wb_dat_i[SPWC_EXT_OVR_MSB:SPWC_EXT_OVR_LSB]))
        else $error("extended override write lost");

    // Restart pulse: one cycle, only on a changed override
    reinit_one_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        reinit_req |=> !reinit_req)
        else $error("restart pulse too long");
    reinit_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr && new_ovr == cur.ovr) |=> !reinit_req)
        else $error("restart on unchanged override");

    // Width decode per override code, always masked by capability
    x1_always_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cur.ovr != SPWC_OVR_X1_R |-> en_x1)
        else $error("single lane not offered");
    x1r_force_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cur.ovr == SPWC_OVR_X1_R |-> en_x1_r && !en_x1 && !en_x2 && !en_x4 && !en_x8)
        else $error("redundant single lane not forced");
    x1r_only_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        en_x1_r |-> cur.ovr == SPWC_OVR_X1_R)
        else $error("redundant lane offered without override");
    x2_only_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cur.ovr == SPWC_OVR_X2 |-> !en_x4 && en_x2 == CAP_WIDTH[1])
        else $error("two-lane-only code misdecoded");
    x4_only_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cur.ovr == SPWC_OVR_X4 |-> !en_x2 && en_x4 == CAP_WIDTH[0])
        else $error("four-lane-only code misdecoded");
    both_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cur.ovr == SPWC_OVR_X2X4 |-> en_x2 == CAP_WIDTH[1] && en_x4 == CAP_WIDTH[0])
        else $error("two and four lane code misdecoded");
    no_ovr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cur.ovr == SPWC_OVR_NONE |-> en_x1 && en_x2 == CAP_WIDTH[1] && en_x4 == CAP_WIDTH[0])
        else $error("no-override code misdecoded");
    reserved_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cur.ovr == 3'h1 || cur.ovr == 3'h4)
        |-> en_x1 && !en_x1_r && !en_x2 && !en_x4 && !en_x8 && !en_x16)
        else $error("reserved code offers extra widths");
    ext_mask_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!en_x8 || CAP_EXT[1]) && (!en_x16 || CAP_EXT[0]))
        else $error("unsupported extended width enabled");
    ext_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cur.ovr != SPWC_OVR_NONE && !cur.ovr[2]) |-> !en_x8 && !en_x16)
        else $error("extended widths offered with bit 5 clear");

    // Traffic gating; these are combinational so checked in the same cycle
    off_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        port_off |-> !tx_allow && !tx_sym_allow && !rx_accept && !rx_reject && !rx_sym_take)
        else $error("traffic passed while port disabled");
    tx_sym_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (tx_sym_req && !port_off) |-> tx_sym_allow)
        else $error("control symbol held back");
    tx_open_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (tx_req && !port_off && cur.out_en) |-> tx_allow)
        else $error("packet held back with output enabled");
    tx_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !tx_req |-> !tx_allow)
        else $error("send allowed with nothing waiting");
    rx_open_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rx_pkt && !port_off && cur.in_en) |-> rx_accept && !rx_reject)
        else $error("packet refused with input enabled");
    rx_maint_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rx_pkt && !port_off && rx_maint) |-> rx_accept && !rx_reject)
        else $error("maintenance packet refused");
    rx_excl_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(rx_accept && rx_reject))
        else $error("packet both accepted and refused");
    rx_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !rx_pkt |-> !rx_accept && !rx_reject)
        else $error("answer without received packet");
endmodule

// [tb/spwc_link_partner.sv]
// Training model of the link partner: answers a restart after a delay
module spwc_link_partner #(
    parameter int         DLY   = 8,        // Cycles from restart to trained
    parameter logic [2:0] WIDTH = 3'h2      // Width code reached by training
) (
    input  wire logic       ref_clk,    // Register clock
    input  wire logic       rstn,       // Asynchronous reset, active low
    input  wire logic       reinit_req, // Restart request from the port
    output logic            init_done,  // Training finished
    output logic [2:0]      init_width  // Width code, garbage until done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // Width shows a wrong code until done, so a port that samples early is caught
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt        <= 0;
            init_done  <= 1'h0;
            init_width <= ~WIDTH;
        end else if (reinit_req) begin
            cnt        <= DLY;
            init_done  <= 1'h0;
            init_width <= ~WIDTH;
        end else if (cnt == 1) begin
            cnt        <= 0;
            init_done  <= 1'h1;
            init_width <= WIDTH;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// [tb/serial_port_width_control_bench.sv]
// Register and traffic-gating bench for the port lane control register
module serial_port_width_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import spwc_pkg::*;
    logic        ref_clk = 1'h0;
    logic        rstn    = 1'h0;
    logic [50:0] req     = '0;
    logic [5:0]  st      = '0;
    logic [31:0] dat_o, q;
    logic        ack, rr, done, reinit_req, port_off;
    logic        en_x1, en_x1_r, en_x2, en_x4, en_x8, en_x16;
    logic        tx_allow, tx_sym_allow, rx_accept, rx_reject, rx_sym_take;
    logic [2:0]  iw, c;
    int          num_errors = 0;
    int          samples_checked = 0;
    logic [2:0]  codes[8] = '{3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h1, 3'h4, 3'h0};

    spwc_core #(.CAP_WIDTH(2'h1)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(req[50]), .wb_stb_i(req[49]),
        .wb_we_i(req[48]), .wb_adr_i(req[47:36]), .wb_sel_i(req[35:32]),
        .wb_dat_i(req[31:0]), .wb_dat_o(dat_o), .wb_ack_o(ack), .init_done(done),
        .init_width(iw), .reinit_req(reinit_req), .en_x1(en_x1), .en_x1_r(en_x1_r),
        .en_x2(en_x2), .en_x4(en_x4), .en_x8(en_x8), .en_x16(en_x16),
        .port_off(port_off), .tx_req(st[5]), .tx_maint(st[4]), .tx_allow(tx_allow),
        .tx_sym_req(st[3]), .tx_sym_allow(tx_sym_allow), .rx_pkt(st[2]),
        .rx_maint(st[1]), .rx_accept(rx_accept), .rx_reject(rx_reject),
        .rx_sym(st[0]), .rx_sym_take(rx_sym_take));
    spwc_link_partner i_partner (
        .ref_clk(ref_clk), .rstn(rstn), .reinit_req(reinit_req),
        .init_done(done), .init_width(iw));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Entered just after a rising edge; returns just after one, bus idle
    task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        int n;
        n = 0;
        req <= {2'b11, w, a, s, d};
        // Ack, restart pulse and read data are all taken at the edge that sees ack high
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'h1 && n < 40);
        if (ack !== 1'h1) begin
            num_errors++;
            tally_and_finish();
        end
        rr = reinit_req;
        q  = dat_o;
        req <= {2'b00, req[48:0]};
        @(posedge ref_clk);
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'h1;
        @(posedge ref_clk);
        bus(1'h0, SPWC_PORT_LANE_CONTROL_ADDR, 4'hf, 32'h0);
        chk("reset", q, 32'h8000_0000);
        bus(1'h1, 12'h000, 4'hf, 32'hffff_ffff);
        bus(1'h0, 12'h000, 4'hf, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(1'h1, SPWC_PORT_LANE_CONTROL_ADDR, 4'h8, 32'hf800_0000);
        bus(1'h0, SPWC_PORT_LANE_CONTROL_ADDR, 4'hf, 32'h0);
        chk("ro_fields", q, 32'h8000_0000);
        foreach (codes[i]) begin
            c = codes[i];
            bus(1'h1, SPWC_PORT_LANE_CONTROL_ADDR, 4'h8, {5'h0, c, 24'h0});
            chk("reinit", rr, 1'h1);
            chk("widths", {en_x1, en_x1_r, en_x2, en_x4, en_x8, en_x16},
                {c != 3'h3, c == 3'h3, 1'h0, c inside {3'h0, 3'h6, 3'h7}, 2'h0});
            bus(1'h0, SPWC_PORT_LANE_CONTROL_ADDR, 4'hf, 32'h0);
            chk("override", q[26:24], c);
        end
        bus(1'h1, SPWC_PORT_LANE_CONTROL_ADDR, 4'h8, 32'h0);
        chk("same_ovr", rr, 1'h0);
        bus(1'h1, SPWC_PORT_LANE_CONTROL_ADDR, 4'h8, 32'h0600_0000);
        bus(1'h0, SPWC_PORT_LANE_CONTROL_ADDR, 4'hf, 32'h0);
        chk("untrained", q, 32'h8600_0000);
        repeat (12) @(posedge ref_clk);
        bus(1'h0, SPWC_PORT_LANE_CONTROL_ADDR, 4'hf, 32'h0);
        chk("trained", q, 32'h9600_0000);
        for (int k = 0; k < 8; k++) begin
            c = k[2:0];
            bus(1'h1, SPWC_PORT_LANE_CONTROL_ADDR, 4'h4, {8'h0, c, 21'h0});
            for (int s = 0; s < 8; s++) begin
                st <= {s[2], s[1], s[2], s[2], s[0], s[2]};
                @(negedge ref_clk);
                chk("gating", {port_off, tx_allow, tx_sym_allow, rx_accept, rx_reject,
                    rx_sym_take}, {c[2], s[2] & !c[2] & (c[1] | s[1]), s[2] & !c[2],
                    s[2] & !c[2] & (c[0] | s[0]), s[2] & !c[2] & !c[0] & !s[0],
                    s[2] & !c[2]});
                @(posedge ref_clk);
            end
        end
        st <= '0;
        bus(1'h1, SPWC_PORT_LANE_CONTROL_ADDR, 4'ha, 32'h0000_c000);
        chk("ext_ovr", {en_x8, en_x16}, 2'h0);
        // Second reset in mid-run must bring back every reset value
        rstn <= 1'h0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'h1;
        @(posedge ref_clk);
        bus(1'h0, SPWC_PORT_LANE_CONTROL_ADDR, 4'hf, 32'h0);
        chk("rereset", q, 32'h8000_0000);
        tally_and_finish();
    end
endmodule
